// [logic/uft_pkg.sv]
package uft_pkg;
	// Transceiver control register, documented special-function address
	localparam logic [7:0] XCN_ADDR        = 8'hd7;
	localparam logic [7:0] XCN_RESET       = 8'h00;
	localparam int         XCN_PULLUP_EN   = 7;
	localparam int         XCN_XCVR_EN     = 6;
	localparam int         XCN_SPEED       = 5;
	localparam int         XCN_TEST_HI     = 4;
	localparam int         XCN_TEST_LO     = 3;
	localparam int         XCN_DIFF_RX     = 2;
	localparam int         XCN_PLUS_LINE   = 1;
	localparam int         XCN_MINUS_LINE  = 0;
	localparam logic [7:0] XCN_WR_MASK     = 8'hf8;

	// Endpoint organisation
	localparam int         EP_COUNT        = 4;
	localparam int         PIPE_COUNT      = 8;
	localparam logic [7:0] EP0_PROTO_ADDR  = 8'h00;
	localparam int         PROTO_DIR_BIT   = 7;

	// Shared endpoint buffer, 1k bytes
	localparam int         EPBUF_BYTES     = 1024;
	localparam int         EPBUF_AW        = 10;

	// Token buffer
	localparam int         TOK_DEPTH       = 2;
	localparam int         TOK_W           = 12;

	typedef enum logic [1:0] {
		UFT_TEST_NORMAL = 2'b00,
		UFT_TEST_DIFF_1 = 2'b01,
		UFT_TEST_DIFF_0 = 2'b10,
		UFT_TEST_SE0    = 2'b11
	} uft_test_t;
endpackage : uft_pkg

// [logic/uft_buf.sv]
`timescale 1ns/100ps
`default_nettype none
module uft_buf #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 2
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	// Shift buffer: entry 0 is always the head, so outputs are flops
	logic [WIDTH-1:0] data       [DEPTH];
	logic [WIDTH-1:0] next_data  [DEPTH];
	logic [DEPTH-1:0] valid;
	logic [DEPTH-1:0] next_valid;
	logic             pop;
	logic             push;

	assign pop  = valid[0] && out_ready_i;
	assign push = in_valid_i && !valid[DEPTH-1];

	always_comb begin
		logic [DEPTH-1:0] kept;
		kept = valid;
		for (int i = 0; i < DEPTH; i++) begin
			next_data[i] = data[i];
		end
		if (pop) begin
			kept = valid >> 1;
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_data[i] = data[i+1];
			end
		end
		next_valid = kept;
		if (push) begin
			// First free entry behind the occupied ones takes the word
			if (!kept[0]) begin
				next_data[0]  = in_data_i;
				next_valid[0] = 1'b1;
			end
			for (int i = 1; i < DEPTH; i++) begin
				if (!kept[i] && kept[i-1]) begin
					next_data[i]  = in_data_i;
					next_valid[i] = 1'b1;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_entry
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					data[g]  <= '0;
					valid[g] <= 1'b0;
				end else begin
					data[g]  <= next_data[g];
					valid[g] <= next_valid[g];
				end
			end
		end
	endgenerate

	assign in_ready_o  = !valid[DEPTH-1];
	assign out_valid_o = valid[0];
	assign out_data_o  = data[0];
endmodule : uft_buf
`default_nettype wire

// [logic/uft_ctrl.sv]
// Function
// - The block is a USB peripheral function only and never acts as a host.
// - Eight endpoint pipes exist: control endpoint zero plus three IN/OUT pairs.
// - Endpoint zero is one bidirectional control endpoint at protocol address 0x00.
// - Endpoints one to three answer at 0x01-0x03 for OUT and 0x81-0x83 for IN.
// - Speed bit 1 selects Full Speed with the enabled pull-up on D+.
// - Speed bit 0 selects Low Speed with the enabled pull-up on D-.
// - The pull-up is applied only while VBUS is present.
// - Low five control bits are two writable test-mode bits and three read-only line states.
// - A shared 1k byte endpoint buffer is provided, and no crystal is needed.
`timescale 1ns/100ps
`default_nettype none
module uft_ctrl (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_n_i,
	// Special-function register port
	input  wire logic [7:0]                 sfr_addr_i,
	input  wire logic                       sfr_wr_i,
	input  wire logic                       sfr_rd_i,
	input  wire logic [7:0]                 sfr_wdata_i,
	output logic      [7:0]                 sfr_rdata_o,
	// Bus lines and detection
	input  wire logic                       vbus_i,
	input  wire logic                       plus_line_i,
	output logic                            plus_line_o,
	output logic                            plus_line_oe_o,
	input  wire logic                       minus_line_i,
	output logic                            minus_line_o,
	output logic                            minus_line_oe_o,
	output logic                            pullup_plus_o,
	output logic                            pullup_minus_o,
	output logic                            transceiver_enable_o,
	output logic                            full_speed_o,
	// Decoded tokens from the serial interface engine
	input  wire logic                       tok_valid_i,
	output logic                            tok_ready_o,
	input  wire logic [3:0]                 tok_endpoint_i,
	input  wire logic                       tok_dir_in_i,
	output logic                            pipe_valid_o,
	input  wire logic                       pipe_ready_i,
	output logic                            pipe_hit_o,
	output logic      [2:0]                 pipe_index_o,
	output logic      [7:0]                 pipe_proto_addr_o,
	// Shared endpoint buffer port
	input  wire logic                       epbuf_wr_i,
	input  wire logic [uft_pkg::EPBUF_AW-1:0] epbuf_addr_i,
	input  wire logic [7:0]                 epbuf_wdata_i,
	output logic      [7:0]                 epbuf_rdata_o
);
	// Control register state
	logic       pullup_enable;
	logic       transceiver_enable;
	logic       speed;
	logic [1:0] phy_test_mode;
	logic       next_pullup_enable;
	logic       next_transceiver_enable;
	logic       next_speed;
	logic [1:0] next_phy_test_mode;
	// Sampled line state
	logic       plus_line_state;
	logic       minus_line_state;
	logic       diff_receiver_state;
	// Registered outputs
	logic [7:0] next_sfr_rdata;
	logic       next_pullup_plus;
	logic       next_pullup_minus;
	logic       next_plus_line;
	logic       next_minus_line;
	logic       next_line_oe;
	logic       sel_xcn;
	logic [7:0] xcn_value;

	assign sel_xcn   = (sfr_addr_i == uft_pkg::XCN_ADDR);
	assign xcn_value = {pullup_enable, transceiver_enable, speed, phy_test_mode,
		diff_receiver_state, plus_line_state, minus_line_state};

	always_comb begin
		next_pullup_enable      = pullup_enable;
		next_transceiver_enable = transceiver_enable;
		next_speed              = speed;
		next_phy_test_mode      = phy_test_mode;
		if (sfr_wr_i && sel_xcn) begin
			// Read-only status bits ignore writes
			next_pullup_enable      = sfr_wdata_i[uft_pkg::XCN_PULLUP_EN];
			next_transceiver_enable = sfr_wdata_i[uft_pkg::XCN_XCVR_EN];
			next_speed              = sfr_wdata_i[uft_pkg::XCN_SPEED];
			next_phy_test_mode      = sfr_wdata_i[uft_pkg::XCN_TEST_HI:uft_pkg::XCN_TEST_LO];
		end
		next_sfr_rdata = (sfr_rd_i && sel_xcn) ? xcn_value : 8'h00;
		// Pull-up placement follows speed, gated by VBUS
		next_pullup_plus  = pullup_enable && vbus_i && speed;
		next_pullup_minus = pullup_enable && vbus_i && !speed;
		// Lines are driven only for test patterns; no host signalling exists
		next_line_oe    = transceiver_enable &&
			(uft_pkg::uft_test_t'(phy_test_mode) != uft_pkg::UFT_TEST_NORMAL);
		next_plus_line  = 1'b0;
		next_minus_line = 1'b0;
		case (uft_pkg::uft_test_t'(phy_test_mode))
			uft_pkg::UFT_TEST_DIFF_1: begin
				next_plus_line = 1'b1;
			end
			uft_pkg::UFT_TEST_DIFF_0: begin
				next_minus_line = 1'b1;
			end
			default: begin
				next_plus_line  = 1'b0;
				next_minus_line = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pullup_enable        <= uft_pkg::XCN_RESET[uft_pkg::XCN_PULLUP_EN];
			transceiver_enable   <= uft_pkg::XCN_RESET[uft_pkg::XCN_XCVR_EN];
			speed                <= uft_pkg::XCN_RESET[uft_pkg::XCN_SPEED];
			phy_test_mode        <= uft_pkg::XCN_RESET[uft_pkg::XCN_TEST_HI:uft_pkg::XCN_TEST_LO];
			plus_line_state      <= 1'b0;
			minus_line_state     <= 1'b0;
			diff_receiver_state  <= 1'b0;
			sfr_rdata_o          <= 8'h00;
			pullup_plus_o        <= 1'b0;
			pullup_minus_o       <= 1'b0;
			transceiver_enable_o <= 1'b0;
			full_speed_o         <= 1'b0;
			plus_line_o          <= 1'b0;
			minus_line_o         <= 1'b0;
			plus_line_oe_o       <= 1'b0;
			minus_line_oe_o      <= 1'b0;
		end else begin
			pullup_enable        <= next_pullup_enable;
			transceiver_enable   <= next_transceiver_enable;
			speed                <= next_speed;
			phy_test_mode        <= next_phy_test_mode;
			plus_line_state      <= plus_line_i;
			minus_line_state     <= minus_line_i;
			diff_receiver_state  <= plus_line_i && !minus_line_i;
			sfr_rdata_o          <= next_sfr_rdata;
			pullup_plus_o        <= next_pullup_plus;
			pullup_minus_o       <= next_pullup_minus;
			transceiver_enable_o <= transceiver_enable;
			full_speed_o         <= speed;
			plus_line_o          <= next_plus_line;
			minus_line_o         <= next_minus_line;
			plus_line_oe_o       <= next_line_oe;
			minus_line_oe_o      <= next_line_oe;
		end
	end

	// Endpoint address decode into the token buffer
	logic [uft_pkg::TOK_W-1:0] tok_word;
	logic [uft_pkg::TOK_W-1:0] pipe_word;
	logic                      tok_hit;
	logic [2:0]                tok_pipe;
	logic [7:0]                tok_proto;

	always_comb begin
		tok_hit   = (tok_endpoint_i < 4'(uft_pkg::EP_COUNT));
		tok_pipe  = {tok_endpoint_i[1:0], tok_dir_in_i};
		tok_proto = uft_pkg::EP0_PROTO_ADDR;
		if (tok_endpoint_i != 4'h0) begin
			tok_proto = {tok_dir_in_i, 3'h0, tok_endpoint_i};
		end
		if (!tok_hit) begin
			tok_pipe  = 3'h0;
			tok_proto = 8'h00;
		end
		tok_word = {tok_hit, tok_pipe, tok_proto};
	end

	uft_buf #(
		.WIDTH (uft_pkg::TOK_W),
		.DEPTH (uft_pkg::TOK_DEPTH)
	) uft_buf_i (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (tok_valid_i),
		.in_ready_o  (tok_ready_o),
		.in_data_i   (tok_word),
		.out_valid_o (pipe_valid_o),
		.out_ready_i (pipe_ready_i),
		.out_data_o  (pipe_word)
	);

	assign pipe_hit_o        = pipe_word[11];
	assign pipe_index_o      = pipe_word[10:8];
	assign pipe_proto_addr_o = pipe_word[7:0];

	// Shared endpoint buffer, clock recovered from the bus upstream
	logic [7:0] epbuf_mem [uft_pkg::EPBUF_BYTES];

	always_ff @(posedge sys_clk_i) begin
		if (epbuf_wr_i) begin
			epbuf_mem[epbuf_addr_i] <= epbuf_wdata_i;
		end
		epbuf_rdata_o <= epbuf_mem[epbuf_addr_i];
	end

	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	pullup_plus_gate_a: assert property (pullup_plus_o |-> $past(pullup_enable && vbus_i && speed))
		else $error("pull-up on plus line without enable, vbus and full speed");
	pullup_minus_gate_a: assert property (pullup_minus_o |-> $past(pullup_enable && vbus_i && !speed))
		else $error("pull-up on minus line without enable, vbus and low speed");
	vbus_drop_a: assert property (!vbus_i |=> !pullup_plus_o && !pullup_minus_o)
		else $error("pull-up kept while vbus absent");
	pullup_excl_a: assert property (!(pullup_plus_o && pullup_minus_o))
		else $error("pull-up on both lines");
	xcn_write_a: assert property ((sfr_wr_i && sel_xcn) ##1 (sfr_rd_i && sel_xcn && !sfr_wr_i)
		|=> sfr_rdata_o[7:3] == $past(sfr_wdata_i[7:3], 2))
		else $error("control bits do not read back");
	ro_bits_a: assert property (sfr_rd_i && sel_xcn |=> sfr_rdata_o[1:0] ==
		{$past(plus_line_state), $past(minus_line_state)})
		else $error("line state bits misreported");
	ep0_addr_a: assert property (pipe_valid_o && pipe_hit_o && pipe_index_o[2:1] == 2'h0
		|-> pipe_proto_addr_o == 8'h00)
		else $error("endpoint zero not at address zero");
	epn_addr_a: assert property (pipe_valid_o && pipe_hit_o && pipe_index_o[2:1] != 2'h0
		|-> pipe_proto_addr_o == {pipe_index_o[0], 5'h00, pipe_index_o[2:1]})
		else $error("endpoint protocol address wrong");
	no_host_drive_a: assert property (plus_line_oe_o |-> $past(transceiver_enable)
		&& $past(phy_test_mode) != 2'h0)
		else $error("lines driven outside test mode");
	tok_hold_a: assert property (pipe_valid_o && !pipe_ready_i |=> pipe_valid_o
		&& $stable(pipe_proto_addr_o))
		else $error("stalled pipe word lost");

	full_speed_c: cover property (pullup_plus_o ##1 pullup_plus_o);
	low_speed_c: cover property (pullup_minus_o ##1 pullup_minus_o);
	buf_full_c: cover property (!tok_ready_o ##1 pipe_valid_o && pipe_ready_i);
	ep3_in_c: cover property (pipe_valid_o && pipe_proto_addr_o == 8'h83);
endmodule : uft_ctrl
`default_nettype wire

// [bench/uft_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module uft_host_model (
	input  wire logic pullup_plus_i,
	input  wire logic pullup_minus_i,
	input  wire logic plus_line_i,
	input  wire logic plus_line_oe_i,
	input  wire logic minus_line_i,
	input  wire logic minus_line_oe_i,
	output logic      plus_line_o,
	output logic      minus_line_o
);
	// Host side holds weak pull-downs, so a released line follows its pull-up and falls to 0 when that pull-up is off
	always_comb begin
		plus_line_o  = plus_line_oe_i ? plus_line_i : pullup_plus_i;
		minus_line_o = minus_line_oe_i ? minus_line_i : pullup_minus_i;
	end
endmodule : uft_host_model
`default_nettype wire

// [bench/usb_function_transceiver_ctrl_test.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module usb_function_transceiver_ctrl_test;
	logic       sys_clk, rst_n = 0, wr = 0, rd = 0, vbus = 0, tv = 0, tdir = 0, prdy = 0, ewr = 0;
	logic [7:0] addr = 0, wdata = 0, rdata, paddr, ewd = 0, erd;
	logic [3:0] tep = 0;
	logic [9:0] eaddr = 0;
	logic [2:0] pidx;
	logic       pl_i, pl_o, pl_oe, mi_i, mi_o, mi_oe, pu_p, pu_m, xen, fs, tr, pv, phit;
	int         failures = 0, comparisons = 0, cycles = 0;

	uft_ctrl uft_ctrl_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .vbus_i(vbus),
		.plus_line_i(pl_i), .plus_line_o(pl_o), .plus_line_oe_o(pl_oe), .minus_line_i(mi_i),
		.minus_line_o(mi_o), .minus_line_oe_o(mi_oe), .pullup_plus_o(pu_p),
		.pullup_minus_o(pu_m), .transceiver_enable_o(xen), .full_speed_o(fs),
		.tok_valid_i(tv), .tok_ready_o(tr), .tok_endpoint_i(tep), .tok_dir_in_i(tdir),
		.pipe_valid_o(pv), .pipe_ready_i(prdy), .pipe_hit_o(phit), .pipe_index_o(pidx),
		.pipe_proto_addr_o(paddr), .epbuf_wr_i(ewr), .epbuf_addr_i(eaddr),
		.epbuf_wdata_i(ewd), .epbuf_rdata_o(erd));
	uft_host_model uft_host_model_i (.pullup_plus_i(pu_p), .pullup_minus_i(pu_m),
		.plus_line_i(pl_o), .plus_line_oe_i(pl_oe), .minus_line_i(mi_o),
		.minus_line_oe_i(mi_oe), .plus_line_o(pl_i), .minus_line_o(mi_i));

	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end

	task wrap_up;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles >= 3000) begin
			failures++;
			wrap_up();
		end
	end

	task sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(negedge sys_clk);
		addr  = a;
		wr    = w;
		rd    = !w;
		wdata = d;
		@(negedge sys_clk);
		wr = 0;
		rd = 0;
	endtask : sfr

	// Write, let pins and line status settle, read back
	task xcn(input logic [7:0] d, input logic [7:0] exp_rd);
		sfr(8'hd7, 1'b1, d);
		repeat (3) @(negedge sys_clk);
		sfr(8'hd7, 1'b0, 8'h00);
		`CHK(rdata, exp_rd)
	endtask : xcn

	task t_reset;
		`CHK({pu_p, pu_m, xen, fs, pl_oe, mi_oe}, 6'h00)
		sfr(8'hd7, 1'b0, 8'h00);
		`CHK(rdata, 8'h00)
	endtask : t_reset

	task t_speed;
		vbus = 1;
		xcn(8'he7, 8'he6);
		`CHK({pu_p, pu_m, xen, fs}, 4'hb)
		xcn(8'h80, 8'h81);
		`CHK({pu_p, pu_m, xen, fs}, 4'h4)
		vbus = 0;
		repeat (3) @(negedge sys_clk);
		`CHK({pu_p, pu_m}, 2'b00)
		sfr(8'hd7, 1'b0, 8'h00);
		`CHK(rdata, 8'h80)
	endtask : t_speed

	task t_test;
		logic [1:0] m;
		logic       p, n;
		for (int i = 1; i < 4; i++) begin
			m = i[1:0];
			p = (m == 2'b01);
			n = (m == 2'b10);
			xcn({3'b010, m, 3'b000}, {3'b010, m, p, p, n});
			`CHK({pl_oe, mi_oe, pl_o, mi_o}, {2'b11, p, n})
		end
		xcn(8'h00, 8'h00);
		`CHK({pl_oe, mi_oe}, 2'b00)
	endtask : t_test

	task t_addr;
		sfr(8'hd6, 1'b1, 8'hff);
		sfr(8'hd6, 1'b0, 8'h00);
		`CHK(rdata, 8'h00)
		sfr(8'hd7, 1'b0, 8'h00);
		`CHK(rdata, 8'h00)
		// Write then read on the very next cycle
		@(negedge sys_clk);
		addr  = 8'hd7;
		wr    = 1;
		wdata = 8'h98;
		@(negedge sys_clk);
		wr = 0;
		rd = 1;
		@(negedge sys_clk);
		rd = 0;
		`CHK(rdata, 8'h98)
		sfr(8'hd7, 1'b1, 8'h00);
	endtask : t_addr

	task push(input logic [3:0] ep, input logic d);
		@(negedge sys_clk);
		tv   = 1;
		tep  = ep;
		tdir = d;
		while (tr !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		tv = 0;
	endtask : push

	task pop(input logic [3:0] ep, input logic d);
		while (pv !== 1'b1) @(negedge sys_clk);
		`CHK(phit, ep < 4)
		`CHK(pidx, (ep < 4) ? {ep[1:0], d} : 3'h0)
		`CHK(paddr, (ep < 4 && ep != 0) ? {d, 5'h00, ep[1:0]} : 8'h00)
		prdy = 1;
		@(negedge sys_clk);
		prdy = 0;
	endtask : pop

	task t_tok;
		for (int e = 0; e < 5; e++)
			for (int d = 0; d < 2; d++) begin
				push(e[3:0], d[0]);
				pop(e[3:0], d[0]);
			end
		push(4'h1, 1'b0);
		push(4'h3, 1'b1);
		@(negedge sys_clk);
		`CHK(tr, 1'b0)
		pop(4'h1, 1'b0);
		push(4'h2, 1'b1);
		pop(4'h3, 1'b1);
		pop(4'h2, 1'b1);
		`CHK(pv, 1'b0)
	endtask : t_tok

	task t_ebuf;
		@(negedge sys_clk);
		ewr   = 1;
		eaddr = 10'h000;
		ewd   = 8'h5a;
		@(negedge sys_clk);
		eaddr = 10'h3ff;
		ewd   = 8'ha5;
		@(negedge sys_clk);
		ewr   = 0;
		eaddr = 10'h000;
		@(negedge sys_clk);
		`CHK(erd, 8'h5a)
		eaddr = 10'h3ff;
		@(negedge sys_clk);
		`CHK(erd, 8'ha5)
	endtask : t_ebuf

	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1;
		t_reset();
		t_speed();
		t_test();
		t_addr();
		t_tok();
		t_ebuf();
		wrap_up();
	end
endmodule : usb_function_transceiver_ctrl_test
`default_nettype wire
